// ==== logic/lcd_channel_diag.sv ====
// Functional notes
// - Sequence enable sends 2^23-1 sequence at E3, 2^15-1 at DS3/STS-1.
// - Sequence enable also turns on the receive checker at once.
// - Checker locked drives the receive negative/violation output low.
// - Out of sync sets sync-loss flag and drives that output high.
// - Error-insert write of one corrupts exactly one transmitted bit.
// - Each detected bit error pulses the output high one receive clock.
// - Only a zero-to-one change of error-insert injects; holding does not.
// - Sequence mode forces single-rail operation whatever the rail setting.
// - Three loopback modes chosen by remote and local loopback bits.
// - Analog loopback feeds transmit line into receive path and outputs.
// - Analog loopback keeps transmitting and ignores the receive line.
// - Digital loopback returns transmit clock and rails to receive outputs.
// - Remote loopback retransmits recovered data on recovered clock timing.
// - Remote loopback ignores terminal transmit clock and rails.
// - All-ones bit sends AMI ones at the terminal transmit clock rate.
// - All-ones suppressed in analog and remote loopback, kept in digital.
`timescale 1ns/1ps
`default_nettype none
module lcd_channel_diag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sequence_enable_bit,
  input wire logic sequence_error_insert_bit,
  input wire logic remote_loopback_bit,
  input wire logic local_loopback_bit,
  input wire logic all_ones_enable_bit,
  input wire logic rate_is_e3,
  input wire logic dual_rail_mode,
  input wire logic terminal_transmit_clock,
  input wire logic transmit_positive_rail,
  input wire logic transmit_negative_rail,
  input wire logic line_recovery_clock,
  input wire logic rx_line_positive,
  input wire logic rx_line_negative,
  output logic tx_line_positive,
  output logic tx_line_negative,
  output logic recovered_receive_clock,
  output logic receive_positive_rail,
  output logic rx_negative_violation_out,
  output logic sequence_sync_loss_flag
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  lcd_pkg::lcd_rail_t tx_s1, tx_s2, tx_s3;
  lcd_pkg::lcd_rail_t rx_s1, rx_s2, rx_s3;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_s1 <= '0;
      tx_s2 <= '0;
      tx_s3 <= '0;
      rx_s1 <= '0;
      rx_s2 <= '0;
      rx_s3 <= '0;
    end else begin
      tx_s1 <= {terminal_transmit_clock, transmit_positive_rail,
                transmit_negative_rail};
      tx_s2 <= tx_s1;
      tx_s3 <= tx_s2;
      rx_s1 <= {line_recovery_clock, rx_line_positive, rx_line_negative};
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  logic tx_tick;
  logic rx_tick;
  assign tx_tick = tx_s2.clk & ~tx_s3.clk;
  assign rx_tick = rx_s2.clk & ~rx_s3.clk;

  // ---------------------------------------------------------------
  // Loopback decode
  // ---------------------------------------------------------------
  lcd_pkg::lcd_loop_t loop_mode;

  always_comb begin
    unique case ({remote_loopback_bit, local_loopback_bit})
      2'b01: loop_mode = lcd_pkg::LB_ANALOG;
      2'b11: loop_mode = lcd_pkg::LB_DIGITAL;
      2'b10: loop_mode = lcd_pkg::LB_REMOTE;
      default: loop_mode = lcd_pkg::LB_NORMAL;
    endcase
  end

  logic is_analog;
  logic is_digital;
  logic is_remote;
  assign is_analog = (loop_mode == lcd_pkg::LB_ANALOG);
  assign is_digital = (loop_mode == lcd_pkg::LB_DIGITAL);
  assign is_remote = (loop_mode == lcd_pkg::LB_REMOTE);

  // Transmit timing follows recovered clock in remote loopback
  logic tx_step;
  assign tx_step = is_remote ? rx_tick : tx_tick;

  // All-ones only outside analog and remote loopback
  logic ones_active;
  assign ones_active = all_ones_enable_bit & ~is_analog & ~is_remote;

  // ---------------------------------------------------------------
  // Error insertion request
  // ---------------------------------------------------------------
  logic insert_prev;
  logic insert_pending;
  logic insert_rise;
  assign insert_rise = sequence_error_insert_bit & ~insert_prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      insert_prev <= 1'b0;
    end else begin
      insert_prev <= sequence_error_insert_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      insert_pending <= 1'b0;
    end else if (insert_rise && sequence_enable_bit) begin
      insert_pending <= 1'b1;
    end else if (insert_pending && tx_step) begin
      insert_pending <= 1'b0;
    end else if (!sequence_enable_bit) begin
      insert_pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Sequence generator
  // ---------------------------------------------------------------
  logic [22:0] gen_reg;
  logic gen_bit;
  assign gen_bit = rate_is_e3 ?
    (gen_reg[lcd_pkg::LONG_TAP_A] ^ gen_reg[lcd_pkg::LONG_TAP_B]) :
    (gen_reg[lcd_pkg::SHORT_TAP_A] ^ gen_reg[lcd_pkg::SHORT_TAP_B]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gen_reg <= lcd_pkg::GEN_SEED;
    end else if (!sequence_enable_bit) begin
      gen_reg <= lcd_pkg::GEN_SEED;
    end else if (tx_step) begin
      gen_reg <= {gen_reg[21:0], gen_bit};
    end
  end

  // ---------------------------------------------------------------
  // Transmit line encoder
  // ---------------------------------------------------------------
  logic ami_phase;
  logic next_tx_pos;
  logic next_tx_neg;
  logic tx_mark;

  always_comb begin
    tx_mark = 1'b0;
    next_tx_pos = 1'b0;
    next_tx_neg = 1'b0;
    if (is_remote) begin
      next_tx_pos = rx_s2.pos;
      next_tx_neg = rx_s2.neg;
    end else if (ones_active) begin
      tx_mark = 1'b1;
      next_tx_pos = ~ami_phase;
      next_tx_neg = ami_phase;
    end else if (sequence_enable_bit || !dual_rail_mode) begin
      tx_mark = sequence_enable_bit ? (gen_bit ^ insert_pending) :
        tx_s2.pos;
      next_tx_pos = tx_mark & ~ami_phase;
      next_tx_neg = tx_mark & ami_phase;
    end else begin
      next_tx_pos = tx_s2.pos;
      next_tx_neg = tx_s2.neg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_line_positive <= 1'b0;
      tx_line_negative <= 1'b0;
      ami_phase <= 1'b0;
    end else if (tx_step) begin
      tx_line_positive <= next_tx_pos;
      tx_line_negative <= next_tx_neg;
      if (tx_mark) begin
        ami_phase <= ~ami_phase;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive source selection
  // ---------------------------------------------------------------
  logic rx_step;
  logic rx_src_pos;
  logic rx_src_neg;
  assign rx_step = is_analog ? tx_tick : rx_tick;
  assign rx_src_pos = is_analog ? tx_line_positive : rx_s2.pos;
  assign rx_src_neg = is_analog ? tx_line_negative : rx_s2.neg;

  logic rx_bit;
  assign rx_bit = rx_src_pos | rx_src_neg;

  // ---------------------------------------------------------------
  // Sequence checker
  // ---------------------------------------------------------------
  logic [22:0] chk_reg;
  logic chk_expect;
  logic chk_err;
  logic in_sync;
  logic [5:0] good_run;
  logic [6:0] clean_run;
  logic [3:0] err_count;

  assign chk_expect = rate_is_e3 ?
    (chk_reg[lcd_pkg::LONG_TAP_A] ^ chk_reg[lcd_pkg::LONG_TAP_B]) :
    (chk_reg[lcd_pkg::SHORT_TAP_A] ^ chk_reg[lcd_pkg::SHORT_TAP_B]);
  assign chk_err = (rx_bit != chk_expect);

  // Seeds from received bits until locked, then flywheels on expected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chk_reg <= lcd_pkg::CHK_SEED;
    end else if (!sequence_enable_bit) begin
      chk_reg <= lcd_pkg::CHK_SEED;
    end else if (rx_step) begin
      chk_reg <= {chk_reg[21:0], in_sync ? chk_expect : rx_bit};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_sync <= 1'b0;
      good_run <= '0;
      clean_run <= '0;
      err_count <= '0;
    end else if (!sequence_enable_bit) begin
      in_sync <= 1'b0;
      good_run <= '0;
      clean_run <= '0;
      err_count <= '0;
    end else if (rx_step) begin
      if (!in_sync) begin
        good_run <= chk_err ? 6'h00 : good_run + 6'h01;
        if (!chk_err && good_run == lcd_pkg::LOCK_COUNT - 6'h01) begin
          in_sync <= 1'b1;
          clean_run <= '0;
          err_count <= '0;
        end
      end else if (chk_err) begin
        clean_run <= '0;
        err_count <= err_count + 4'h1;
        if (err_count == lcd_pkg::LOSS_COUNT - 4'h1) begin
          in_sync <= 1'b0;
          good_run <= '0;
        end
      end else if (clean_run == lcd_pkg::CLEAN_COUNT - 7'h01) begin
        clean_run <= '0;
        err_count <= '0;
      end else begin
        clean_run <= clean_run + 7'h01;
      end
    end
  end

  // Error marker held for one receive clock period
  logic err_hold;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_hold <= 1'b0;
    end else if (!sequence_enable_bit) begin
      err_hold <= 1'b0;
    end else if (rx_step) begin
      err_hold <= in_sync & chk_err;
    end
  end

  // ---------------------------------------------------------------
  // Receive outputs
  // ---------------------------------------------------------------
  logic rx_pos_hold;
  logic rx_neg_hold;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_pos_hold <= 1'b0;
      rx_neg_hold <= 1'b0;
    end else if (rx_step) begin
      rx_pos_hold <= rx_src_pos;
      rx_neg_hold <= rx_src_neg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recovered_receive_clock <= 1'b0;
      receive_positive_rail <= 1'b0;
      rx_negative_violation_out <= 1'b0;
    end else begin
      if (is_digital) begin
        recovered_receive_clock <= tx_s2.clk;
        receive_positive_rail <= tx_s2.pos;
      end else begin
        recovered_receive_clock <= is_analog ? tx_s2.clk : rx_s2.clk;
        receive_positive_rail <= rx_pos_hold;
      end
      if (sequence_enable_bit) begin
        rx_negative_violation_out <= ~in_sync | err_hold;
      end else if (is_digital) begin
        rx_negative_violation_out <= tx_s2.neg;
      end else begin
        rx_negative_violation_out <= rx_neg_hold;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sequence_sync_loss_flag <= 1'b0;
    end else begin
      sequence_sync_loss_flag <= sequence_enable_bit & ~in_sync;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_ins_request;
    insert_rise && sequence_enable_bit;
  endsequence

  sequence s_ins_step;
    insert_pending && tx_step && !insert_rise;
  endsequence

  property p_ins_set;
    @(posedge clk) disable iff (!rst_n)
    s_ins_request |=> insert_pending;
  endproperty
  a_ins_set: assert property (p_ins_set)
    else $error("error insert request not taken");

  property p_ins_once;
    @(posedge clk) disable iff (!rst_n)
    s_ins_step |=> !insert_pending;
  endproperty
  a_ins_once: assert property (p_ins_once)
    else $error("inserted error not consumed after one bit");

  property p_ins_level;
    @(posedge clk) disable iff (!rst_n)
    (sequence_error_insert_bit && insert_prev) |=> !$rose(insert_pending);
  endproperty
  a_ins_level: assert property (p_ins_level)
    else $error("held insert bit injected again");

  property p_lost_high;
    @(posedge clk) disable iff (!rst_n)
    (sequence_enable_bit && !in_sync) |=>
      (rx_negative_violation_out && sequence_sync_loss_flag);
  endproperty
  a_lost_high: assert property (p_lost_high)
    else $error("sync loss not reported");

  property p_lock_low;
    @(posedge clk) disable iff (!rst_n)
    (sequence_enable_bit && in_sync && !err_hold) |=>
      !rx_negative_violation_out;
  endproperty
  a_lock_low: assert property (p_lock_low)
    else $error("locked checker not shown low");

  property p_err_pulse;
    @(posedge clk) disable iff (!rst_n)
    (sequence_enable_bit && rx_step && in_sync && chk_err) |=>
      err_hold ##1 rx_negative_violation_out;
  endproperty
  a_err_pulse: assert property (p_err_pulse)
    else $error("bit error not pulsed");

  property p_err_end;
    @(posedge clk) disable iff (!rst_n)
    (err_hold && rx_step && !chk_err) |=> !err_hold;
  endproperty
  a_err_end: assert property (p_err_end)
    else $error("error pulse longer than one receive clock");

  property p_ones;
    @(posedge clk) disable iff (!rst_n)
    (ones_active && tx_step) |=> (tx_line_positive != tx_line_negative);
  endproperty
  a_ones: assert property (p_ones)
    else $error("all-ones mark missing");

  property p_remote;
    @(posedge clk) disable iff (!rst_n)
    (is_remote && rx_tick) |=>
      (tx_line_positive == $past(rx_s2.pos) &&
       tx_line_negative == $past(rx_s2.neg));
  endproperty
  a_remote: assert property (p_remote)
    else $error("remote loopback data not retransmitted");

  property p_digital;
    @(posedge clk) disable iff (!rst_n)
    (is_digital && !sequence_enable_bit) |=>
      (recovered_receive_clock == $past(tx_s2.clk) &&
       rx_negative_violation_out == $past(tx_s2.neg));
  endproperty
  a_digital: assert property (p_digital)
    else $error("digital loopback not returned");

endmodule : lcd_channel_diag
`default_nettype wire

// ==== logic/lcd_pkg.sv ====
`default_nettype none
package lcd_pkg;

  // ---------------------------------------------------------------
  // Sequence geometry
  // ---------------------------------------------------------------
  localparam int unsigned SEQ_WIDTH = 23;
  localparam int unsigned LONG_TAP_A = 22;
  localparam int unsigned LONG_TAP_B = 17;
  localparam int unsigned SHORT_TAP_A = 14;
  localparam int unsigned SHORT_TAP_B = 13;
  localparam logic [22:0] GEN_SEED = 23'h7FFFFF;
  localparam logic [22:0] CHK_SEED = 23'h000000;

  // ---------------------------------------------------------------
  // Checker thresholds
  // ---------------------------------------------------------------
  localparam logic [5:0] LOCK_COUNT = 6'h20;
  localparam logic [6:0] CLEAN_COUNT = 7'h40;
  localparam logic [3:0] LOSS_COUNT = 4'h8;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
  } lcd_rail_t;

  typedef enum logic [1:0] {
    LB_NORMAL,
    LB_ANALOG,
    LB_DIGITAL,
    LB_REMOTE
  } lcd_loop_t;

endpackage : lcd_pkg
`default_nettype wire

// ==== test/lcd_term_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcd_term_model (
  input wire logic pos_next,
  input wire logic neg_next,
  output logic terminal_transmit_clock,
  output wire logic transmit_positive_rail,
  output wire logic transmit_negative_rail
);
  logic pos_q = 1'b0;
  logic neg_q = 1'b0;

  assign transmit_positive_rail = pos_q;
  assign transmit_negative_rail = neg_q;

  // ---------------------------------------------------------------
  // Free-running framer clock, rails launched on its falling edge
  // ---------------------------------------------------------------
  initial begin
    terminal_transmit_clock = 1'b0;
    #3;
    forever #62.5 terminal_transmit_clock = ~terminal_transmit_clock;
  end

  always @(negedge terminal_transmit_clock) begin
    pos_q <= pos_next;
    neg_q <= neg_next;
  end
endmodule : lcd_term_model
`default_nettype wire

// ==== test/line_channel_diagnostics_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module line_channel_diagnostics_bench;
  logic clk = 1'b0;
  logic rst_n, sequence_enable_bit, sequence_error_insert_bit;
  logic remote_loopback_bit, local_loopback_bit, all_ones_enable_bit;
  logic rate_is_e3, dual_rail_mode, line_recovery_clock;
  logic rx_line_positive, rx_line_negative, pos_next, neg_next;
  logic terminal_transmit_clock, transmit_positive_rail;
  logic transmit_negative_rail, tx_line_positive, tx_line_negative;
  logic recovered_receive_clock, receive_positive_rail;
  logic rx_negative_violation_out, sequence_sync_loss_flag;
  int miscompares = 0;
  int num_checks = 0;
  int pulses = 0;
  int pulse_base = 0;
  int pos_tally, neg_tally, both_tally;
  logic [63:0] hist = '0;
  logic [7:0] seed = 8'h2A;
  logic [7:0] lseed = 8'h2A;
  logic [7:0] bad_cnt;
  logic [1:0] rp;
  logic viol_d = 1'b0;
  string q_name[$];
  logic [7:0] q_exp[$];
  string cur;
  event chk_ev;

  lcd_channel_diag lcd_channel_diag_i (
    .clk(clk), .rst_n(rst_n),
    .sequence_enable_bit(sequence_enable_bit),
    .sequence_error_insert_bit(sequence_error_insert_bit),
    .remote_loopback_bit(remote_loopback_bit),
    .local_loopback_bit(local_loopback_bit),
    .all_ones_enable_bit(all_ones_enable_bit),
    .rate_is_e3(rate_is_e3), .dual_rail_mode(dual_rail_mode),
    .terminal_transmit_clock(terminal_transmit_clock),
    .transmit_positive_rail(transmit_positive_rail),
    .transmit_negative_rail(transmit_negative_rail),
    .line_recovery_clock(line_recovery_clock),
    .rx_line_positive(rx_line_positive),
    .rx_line_negative(rx_line_negative),
    .tx_line_positive(tx_line_positive),
    .tx_line_negative(tx_line_negative),
    .recovered_receive_clock(recovered_receive_clock),
    .receive_positive_rail(receive_positive_rail),
    .rx_negative_violation_out(rx_negative_violation_out),
    .sequence_sync_loss_flag(sequence_sync_loss_flag)
  );

  lcd_term_model lcd_term_model_i (
    .pos_next(pos_next), .neg_next(neg_next),
    .terminal_transmit_clock(terminal_transmit_clock),
    .transmit_positive_rail(transmit_positive_rail),
    .transmit_negative_rail(transmit_negative_rail)
  );

  // ---------------------------------------------------------------
  // Clocks, line stimulus and error pulse counter
  // ---------------------------------------------------------------
  always #5 clk = ~clk;

  initial begin
    line_recovery_clock = 1'b0;
    #37;
    forever #62.5 line_recovery_clock = ~line_recovery_clock;
  end

  always @(negedge line_recovery_clock) begin
    lseed <= lfsr(lseed);
    rx_line_positive <= lseed[2];
    rx_line_negative <= lseed[5];
  end

  always @(negedge clk) begin
    viol_d <= rx_negative_violation_out;
    if (sequence_enable_bit && rx_negative_violation_out && !viol_d) begin
      pulses <= pulses + 1;
    end
  end

  // ---------------------------------------------------------------
  // Expectation queue and its watcher
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic [7:0] observe(input string n);
    case (n)
      "outs": return {2'h0, tx_line_positive, tx_line_negative,
        recovered_receive_clock, receive_positive_rail,
        rx_negative_violation_out, sequence_sync_loss_flag};
      "status": return {6'h0, sequence_sync_loss_flag,
        rx_negative_violation_out};
      "flag": return {7'h0, sequence_sync_loss_flag};
      "loop": return {5'h0, recovered_receive_clock, receive_positive_rail,
        rx_negative_violation_out};
      "tx": return {6'h0, tx_line_positive, tx_line_negative};
      "pulses": return 8'(pulses - pulse_base);
      "pos_tally": return 8'(pos_tally);
      "neg_tally": return 8'(neg_tally);
      "both_tally": return 8'(both_tally);
      default: return bad_cnt;
    endcase
  endfunction : observe

  task automatic compare_val(input string n, input logic [7:0] e,
                             input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
      miscompares++;
    end
  endtask : compare_val

  always @(chk_ev) begin
    while (q_name.size() > 0) begin
      cur = q_name.pop_front();
      compare_val(cur, q_exp.pop_front(), observe(cur));
    end
  end

  task automatic expect_val(input string n, input logic [7:0] e);
    q_name.push_back(n);
    q_exp.push_back(e);
    -> chk_ev;
  endtask : expect_val

  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // Line sampling helpers
  // ---------------------------------------------------------------
  task automatic line_bits(input int n);
    pos_tally = 0;
    neg_tally = 0;
    both_tally = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge terminal_transmit_clock);
      hist = {hist[62:0], tx_line_positive | tx_line_negative};
      pos_tally += int'(tx_line_positive);
      neg_tally += int'(tx_line_negative);
      both_tally += int'(tx_line_positive & tx_line_negative);
    end
  endtask : line_bits

  function automatic logic [7:0] prbs_bad(input logic e3, input int nb);
    int ta, tb;
    logic [7:0] c;
    ta = e3 ? int'(lcd_pkg::LONG_TAP_A) + 1 : int'(lcd_pkg::SHORT_TAP_A) + 1;
    tb = e3 ? int'(lcd_pkg::LONG_TAP_B) + 1 : int'(lcd_pkg::SHORT_TAP_B) + 1;
    c = 8'h00;
    for (int i = 0; i + ta < nb; i++) begin
      if (hist[i] !== (hist[i + ta] ^ hist[i + tb])) c++;
    end
    return c;
  endfunction : prbs_bad

  task automatic wait_lock();
    int n;
    n = 0;
    while (sequence_sync_loss_flag !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      $display("CHECK FAILED lock expected 0 seen 1");
      summarize();
    end
  endtask : wait_lock

  initial begin
    #500000;
    miscompares++;
    $display("CHECK FAILED run expected done seen hang");
    summarize();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {sequence_enable_bit, sequence_error_insert_bit} = 2'b00;
    {remote_loopback_bit, local_loopback_bit} = 2'b11;
    {all_ones_enable_bit, rate_is_e3, dual_rail_mode} = 3'b001;
    {pos_next, neg_next} = 2'b00;
    repeat (2) @(negedge clk);
    expect_val("outs", 8'h00);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      seed = lfsr(seed);
      pos_next = seed[0];
      neg_next = seed[1];
      @(negedge terminal_transmit_clock);
      @(posedge terminal_transmit_clock);
      repeat (6) @(negedge clk);
      expect_val("loop", {5'h0, 1'b1, seed[0], seed[1]});
    end
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      {remote_loopback_bit, local_loopback_bit} = m[0] ? 2'b11 : 2'b00;
      {all_ones_enable_bit, dual_rail_mode} = 2'b10;
      line_bits(2);
      line_bits(8);
      expect_val("pos_tally", 8'h04);
      expect_val("neg_tally", 8'h04);
      expect_val("both_tally", 8'h00);
    end
    @(negedge clk);
    {remote_loopback_bit, local_loopback_bit, dual_rail_mode} = 3'b101;
    repeat (2) @(negedge line_recovery_clock);
    #1;
    rp = {rx_line_positive, rx_line_negative};
    for (int i = 0; i < 8; i++) begin
      @(negedge line_recovery_clock);
      expect_val("tx", {6'h0, rp});
      expect_val("loop", {5'h0, 1'b1, rp});
      #1;
      rp = {rx_line_positive, rx_line_negative};
    end
    for (int r = 0; r < 2; r++) begin
      @(negedge clk);
      {remote_loopback_bit, local_loopback_bit} = 2'b01;
      rate_is_e3 = r[0];
      sequence_enable_bit = 1'b1;
      repeat (3) @(negedge clk);
      expect_val("status", 8'h03);
      wait_lock();
      expect_val("status", 8'h00);
      line_bits(48);
      bad_cnt = prbs_bad(r[0], 48);
      expect_val("prbs_bad", 8'h00);
      expect_val("both_tally", 8'h00);
      pulse_base = pulses;
      @(negedge clk);
      sequence_error_insert_bit = 1'b1;
      line_bits(40);
      expect_val("pulses", 8'h01);
      line_bits(40);
      expect_val("pulses", 8'h01);
      @(negedge clk);
      sequence_error_insert_bit = 1'b0;
      line_bits(2);
      @(negedge clk);
      sequence_error_insert_bit = 1'b1;
      line_bits(40);
      expect_val("pulses", 8'h02);
      expect_val("status", 8'h00);
      @(negedge clk);
      {sequence_enable_bit, sequence_error_insert_bit} = 2'b00;
      repeat (3) @(negedge clk);
      expect_val("flag", 8'h00);
    end
    #1;
    summarize();
  end
endmodule : line_channel_diagnostics_bench
`default_nettype wire
